// ---- dlc_defs.svh ----
// Constants for the dual limit checker
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH
`define DLC_NUM_TESTS 2
`define DLC_NUM_CH 4
`define DLC_VAL_W 33
`define DLC_UPPER1_RST 33'sh000000001
`define DLC_UPPER2_RST 33'sh000000002
`define DLC_LOWER1_RST 33'sh1FFFFFFFF
`define DLC_LOWER2_RST 33'sh1FFFFFFFE
`define DLC_CLK_HZ 50000000
`define DLC_PULSE_MS_MIN 1
`define DLC_PULSE_MS_MAX 99999999
`define DLC_PULSE_MS_RST 2
`define DLC_CYC_PER_MS (`DLC_CLK_HZ / 1000)
`endif

// ---- dlc_pkg.sv ----
// Types shared by the dual limit checker files
`default_nettype none
package dlc_pkg;
    typedef enum logic [2:0] {
        DLC_IDLE = 3'b001,
        DLC_PULSE = 3'b010,
        DLC_HOLD = 3'b100
    } dlc_pulse_state_e;
    typedef logic [32:0] dlc_val_t;
endpackage
`default_nettype wire

// ---- dlc_pulse_gen.sv ----
// One limit output line driver with level or timed pulse mode
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defs.svh"
module dlc_pulse_gen
    import dlc_pkg::*;
#(
    parameter int CYC_PER_MS = `DLC_CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic fail_i,
    input wire logic pulse_mode_i,
    input wire logic [26:0] pulse_ms_i,
    // Asserted level, true polarity
    output logic assert_o
);
    dlc_pulse_state_e state_reg, state_next;
    logic [15:0] cyc_reg, cyc_next;
    logic [26:0] ms_reg, ms_next;
    logic out_reg, out_next;
    logic fail_d_reg;
    logic rise;

    assign rise = fail_i & ~fail_d_reg;

    // Next state; a fresh failure starts a pulse, a steady failure holds off
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        ms_next = ms_reg;
        out_next = 1'b0;
        case (state_reg)
            DLC_IDLE: begin
                if (!pulse_mode_i) begin
                    out_next = fail_i;
                end else if (rise) begin
                    state_next = DLC_PULSE;
                    cyc_next = 16'h0000;
                    ms_next = 27'h0000000;
                    out_next = 1'b1;
                end
            end
            DLC_PULSE: begin
                out_next = 1'b1;
                if (cyc_reg == 16'(CYC_PER_MS - 1)) begin
                    cyc_next = 16'h0000;
                    ms_next = ms_reg + 27'h0000001;
                    // Width counted in whole milliseconds
                    if (ms_reg + 27'h0000001 >= pulse_ms_i) begin
                        out_next = 1'b0;
                        state_next = DLC_HOLD;
                    end
                end else begin
                    cyc_next = cyc_reg + 16'h0001;
                end
                if (!pulse_mode_i) begin
                    state_next = DLC_IDLE;
                    out_next = fail_i;
                end
            end
            DLC_HOLD: begin
                if (!fail_i || !pulse_mode_i) begin
                    state_next = DLC_IDLE;
                end
            end
            default: begin
                state_next = DLC_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= DLC_IDLE;
            cyc_reg <= 16'h0000;
            ms_reg <= 27'h0000000;
            out_reg <= 1'b0;
            fail_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            ms_reg <= ms_next;
            out_reg <= out_next;
            fail_d_reg <= fail_i;
        end
    end

    assign assert_o = out_reg;
endmodule // dlc_pulse_gen
`default_nettype wire

// ---- dlc_limit_checker.sv ----
// Dual limit checker: two bound tests, events, master fail, limit lines
// Functional notes
// - Two independent tests with own controls
// - Upper bound signed, per channel, resets 1/2
// - Lower bound signed, per channel, resets -1/-2
// - Per-channel enable off; disabled never fails
// - Result bit reads one while failing
// - Clear request resets both events
// - Auto clear, default on, clears stored events
// - Master latch selects held or following
// - Lines driven only when output enabled
// - Pulse mode makes timed pulses, readable
// - Pulse width 1 ms to 99999999 ms
// - One polarity for all lines, high default
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defs.svh"
module dlc_limit_checker
    import dlc_pkg::*;
#(
    parameter int NUM_CH = `DLC_NUM_CH,
    parameter int CH_W = 2,
    parameter int CYC_PER_MS = `DLC_CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bound writes, one test and channel at a time
    input wire logic bound_we_i,
    input wire logic bound_test_i,
    input wire logic bound_upper_i,
    input wire logic [CH_W-1:0] bound_ch_i,
    input wire logic [32:0] bound_val_i,
    // Per-test, per-channel enable writes
    input wire logic en_we_i,
    input wire logic en_test_i,
    input wire logic [CH_W-1:0] en_ch_i,
    input wire logic en_val_i,
    // Event clear and auto-clear settings per test
    input wire logic [1:0] clear_req_i,
    input wire logic [1:0] auto_clear_we_i,
    input wire logic [1:0] auto_clear_val_i,
    // Global settings
    input wire logic cfg_we_i,
    input wire logic master_hold_enable_i,
    input wire logic out_enable_i,
    input wire logic pulse_mode_i,
    input wire logic output_polarity_select_i,
    input wire logic [26:0] pulse_ms_i,
    // Reading path
    input wire logic reading_valid_i,
    input wire logic [CH_W-1:0] reading_ch_i,
    input wire logic [32:0] reading_i,
    // Readback of bounds and settings
    input wire logic [CH_W-1:0] rd_ch_i,
    output logic [32:0] upper1_o,
    output logic [32:0] lower1_o,
    output logic [32:0] upper2_o,
    output logic [32:0] lower2_o,
    output logic [1:0] test_en_o,
    output logic [1:0] auto_clear_o,
    output logic master_hold_enable_o,
    output logic out_enable_o,
    output logic pulse_mode_o,
    output logic output_polarity_select_o,
    output logic [26:0] pulse_ms_o,
    // Results
    output logic [1:0] high_event_o,
    output logic [1:0] low_event_o,
    output logic [1:0] fail_o,
    output logic master_fail_o,
    // Limit lines: two tests then master
    output logic [2:0] limit_line_o,
    output logic [2:0] limit_line_oe_o
);
    ////////////////////////////////////////////////////////////////////////
    // Per-channel bound and enable storage
    ////////////////////////////////////////////////////////////////////////
    dlc_val_t up_reg [2][NUM_CH];
    dlc_val_t lo_reg [2][NUM_CH];
    logic en_reg [2][NUM_CH];
    logic [1:0] hi_ev_reg, hi_ev_next;
    logic [1:0] lo_ev_reg, lo_ev_next;
    logic [1:0] auto_reg, auto_next;
    logic hold_reg, hold_next;
    logic oen_reg, oen_next;
    logic pmode_reg, pmode_next;
    logic pol_reg, pol_next;
    logic [26:0] pms_reg, pms_next;
    logic master_reg, master_next;
    logic [2:0] line_reg, line_next;
    logic [2:0] asrt;
    logic [2:0] line_fail;
    logic [1:0] hit_hi, hit_lo, fail_now;

    for (genvar t = 0; t < 2; t++) begin : g_test
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    up_reg[t][c] <= (t == 0) ? `DLC_UPPER1_RST
                                             : `DLC_UPPER2_RST;
                    lo_reg[t][c] <= (t == 0) ? `DLC_LOWER1_RST
                                             : `DLC_LOWER2_RST;
                    en_reg[t][c] <= 1'b0;
                end else begin
                    if (bound_we_i && bound_test_i == 1'(t)
                        && bound_ch_i == CH_W'(c)) begin
                        if (bound_upper_i) begin
                            up_reg[t][c] <= bound_val_i;
                        end else begin
                            lo_reg[t][c] <= bound_val_i;
                        end
                    end
                    if (en_we_i && en_test_i == 1'(t)
                        && en_ch_i == CH_W'(c)) begin
                        en_reg[t][c] <= en_val_i;
                    end
                end
            end
        end
        assign hit_hi[t] = reading_valid_i && en_reg[t][reading_ch_i]
            && ($signed(reading_i) > $signed(up_reg[t][reading_ch_i]));
        assign hit_lo[t] = reading_valid_i && en_reg[t][reading_ch_i]
            && ($signed(reading_i) < $signed(lo_reg[t][reading_ch_i]));
        // Power of two channel count assumed for the index width
        assign test_en_o[t] = en_reg[t][rd_ch_i];
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, settings and master fail
    ////////////////////////////////////////////////////////////////////////
    // Event next values; later branches take priority
    always_comb begin
        hi_ev_next = hi_ev_reg;
        lo_ev_next = lo_ev_reg;
        auto_next = auto_reg;
        for (int t = 0; t < 2; t++) begin
            if (auto_clear_we_i[t]) begin
                auto_next[t] = auto_clear_val_i[t];
            end
            // auto clear: each reading refreshes the events
            if (auto_reg[t] && reading_valid_i) begin
                hi_ev_next[t] = 1'b0;
                lo_ev_next[t] = 1'b0;
            end
            if (clear_req_i[t]) begin
                hi_ev_next[t] = 1'b0;
                lo_ev_next[t] = 1'b0;
            end
            if (hit_hi[t]) begin
                hi_ev_next[t] = 1'b1;
            end
            if (hit_lo[t]) begin
                lo_ev_next[t] = 1'b1;
            end
        end
    end

    assign fail_now = hi_ev_next | lo_ev_next;

    // Settings and master fail next values
    always_comb begin
        hold_next = hold_reg;
        oen_next = oen_reg;
        pmode_next = pmode_reg;
        pol_next = pol_reg;
        pms_next = pms_reg;
        if (cfg_we_i) begin
            hold_next = master_hold_enable_i;
            oen_next = out_enable_i;
            pmode_next = pulse_mode_i;
            pol_next = output_polarity_select_i;
            // width clamped into its legal range
            if (pulse_ms_i < 27'(`DLC_PULSE_MS_MIN)) begin
                pms_next = 27'(`DLC_PULSE_MS_MIN);
            end else if (pulse_ms_i > 27'(`DLC_PULSE_MS_MAX)) begin
                pms_next = 27'(`DLC_PULSE_MS_MAX);
            end else begin
                pms_next = pulse_ms_i;
            end
        end
        // held once set, or following results
        if (hold_reg) begin
            master_next = master_reg | (|fail_now);
        end else begin
            master_next = |fail_now;
        end
    end

    // Event, setting and master registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_ev_reg <= 2'h0;
            lo_ev_reg <= 2'h0;
            auto_reg <= 2'h3;
            hold_reg <= 1'b0;
            oen_reg <= 1'b0;
            pmode_reg <= 1'b0;
            pol_reg <= 1'b0;
            pms_reg <= 27'(`DLC_PULSE_MS_RST);
            master_reg <= 1'b0;
        end else begin
            hi_ev_reg <= hi_ev_next;
            lo_ev_reg <= lo_ev_next;
            auto_reg <= auto_next;
            hold_reg <= hold_next;
            oen_reg <= oen_next;
            pmode_reg <= pmode_next;
            pol_reg <= pol_next;
            pms_reg <= pms_next;
            master_reg <= master_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit line drivers
    ////////////////////////////////////////////////////////////////////////
    // Failure level per line: test one, test two, master
    assign line_fail = {master_reg, hi_ev_reg | lo_ev_reg};

    for (genvar l = 0; l < 3; l++) begin : g_line
        dlc_pulse_gen #(
            .CYC_PER_MS(CYC_PER_MS)
        ) u_pulse (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .fail_i(line_fail[l]),
            .pulse_mode_i(pmode_reg),
            .pulse_ms_i(pms_reg),
            .assert_o(asrt[l])
        );
    end

    // one polarity for every line; receiver follows it
    always_comb begin
        line_next = pol_reg ? ~asrt : asrt;
    end

    // Registered lines keep decode glitches off the pins
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_reg <= 3'h0;
        end else begin
            line_reg <= line_next;
        end
    end

    assign limit_line_o = oen_reg ? line_reg : 3'h0;
    assign limit_line_oe_o = {3{oen_reg}};

    // Readback
    assign upper1_o = up_reg[0][rd_ch_i];
    assign lower1_o = lo_reg[0][rd_ch_i];
    assign upper2_o = up_reg[1][rd_ch_i];
    assign lower2_o = lo_reg[1][rd_ch_i];
    assign auto_clear_o = auto_reg;
    assign master_hold_enable_o = hold_reg;
    assign out_enable_o = oen_reg;
    assign pulse_mode_o = pmode_reg;
    assign output_polarity_select_o = pol_reg;
    assign pulse_ms_o = pms_reg;
    assign high_event_o = hi_ev_reg;
    assign low_event_o = lo_ev_reg;
    assign fail_o = hi_ev_reg | lo_ev_reg;
    assign master_fail_o = master_reg;
endmodule // dlc_limit_checker
`default_nettype wire

// ---- dlc_limit_checker_chk.sv ----
// Port timing checker for the dual limit checker
`timescale 1ns/1ps
`default_nettype none
module dlc_limit_checker_chk #(
    parameter int CH_W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Reading path and readback channel
    input wire logic reading_valid_i,
    input wire logic [CH_W-1:0] reading_ch_i,
    input wire logic [CH_W-1:0] rd_ch_i,
    input wire logic [32:0] reading_i,
    input wire logic [32:0] upper1_o,
    input wire logic [32:0] lower2_o,
    // Results and settings
    input wire logic [1:0] clear_req_i,
    input wire logic [1:0] test_en_o,
    input wire logic [1:0] fail_o,
    input wire logic [1:0] high_event_o,
    input wire logic [1:0] low_event_o,
    input wire logic master_fail_o,
    input wire logic master_hold_enable_o,
    input wire logic out_enable_o,
    input wire logic [26:0] pulse_ms_o,
    input wire logic [2:0] limit_line_o,
    input wire logic [2:0] limit_line_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Only readings on the readback channel can be judged here
    wire logic hit = reading_valid_i && rd_ch_i == reading_ch_i;
    ////////////////////////////////////////////////////////////////////
    evt_hi_a:
        assert property (hit && test_en_o[0] &&
            $signed(reading_i) > $signed(upper1_o) |=> high_event_o[0])
        else $error("high event not set");
    evt_lo_a:
        assert property (hit && test_en_o[1] &&
            $signed(reading_i) < $signed(lower2_o) |=> low_event_o[1])
        else $error("low event not set");
    evt_cause_a:
        assert property ($rose(high_event_o[0]) || $rose(low_event_o[1])
            |-> $past(reading_valid_i))
        else $error("event without reading");
    fail_or_a:
        assert property (fail_o == (high_event_o | low_event_o))
        else $error("fail differs from events");
    clr_evt_a:
        assert property (clear_req_i[0] && !reading_valid_i
            |=> !high_event_o[0] && !low_event_o[0])
        else $error("events not cleared");
    mst_follow_a:
        assert property (!master_hold_enable_o && $past(!master_hold_enable_o)
            |-> master_fail_o == |fail_o)
        else $error("master does not follow");
    mst_hold_a:
        assert property (master_hold_enable_o && master_fail_o ##1
            master_hold_enable_o |-> master_fail_o)
        else $error("master not held");
    oe_off_a:
        assert property (!out_enable_o && !$past(out_enable_o) &&
            !$past(out_enable_o, 2) |-> limit_line_o == 3'h0)
        else $error("line driven while off");
    oe_all_a:
        assert property (limit_line_oe_o == {3{out_enable_o}})
        else $error("line enable wrong");
    pw_range_a:
        assert property (pulse_ms_o != 27'h0 && pulse_ms_o <= 27'h5F5E0FF)
        else $error("pulse width out of range");
    // Main scenarios reached
    cover property ($rose(high_event_o[0]));
    cover property (master_hold_enable_o && master_fail_o);
    cover property ($rose(limit_line_o[0]));
endmodule // dlc_limit_checker_chk
bind dlc_limit_checker dlc_limit_checker_chk #(.CH_W(CH_W))
    dlc_limit_checker_chk_inst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .reading_valid_i(reading_valid_i),
    .reading_ch_i(reading_ch_i),
    .rd_ch_i(rd_ch_i),
    .reading_i(reading_i),
    .upper1_o(upper1_o),
    .lower2_o(lower2_o),
    .clear_req_i(clear_req_i),
    .test_en_o(test_en_o),
    .fail_o(fail_o),
    .high_event_o(high_event_o),
    .low_event_o(low_event_o),
    .master_fail_o(master_fail_o),
    .master_hold_enable_o(master_hold_enable_o),
    .out_enable_o(out_enable_o),
    .pulse_ms_o(pulse_ms_o),
    .limit_line_o(limit_line_o),
    .limit_line_oe_o(limit_line_oe_o)
);
`default_nettype wire

// ---- dlc_line_sampler.sv ----
// Model of outside equipment sampling the limit lines
`timescale 1ns/1ps
`default_nettype none
module dlc_line_sampler (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Lines as seen on the pins
    input wire logic [2:0] line_i,
    input wire logic [2:0] oe_i,
    input wire logic low_i,
    // What the equipment makes of them
    output logic [2:0] act_o,
    output logic [15:0] width_o
);
    logic [15:0] run;
    always_comb act_o = oe_i & (low_i ? ~line_i : line_i);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run <= 16'h0;
            width_o <= 16'h0;
        end else if (act_o[0]) begin
            run <= run + 16'h1;
        end else begin
            if (run != 16'h0) width_o <= run;
            run <= 16'h0;
        end
    end
endmodule // dlc_line_sampler
`default_nettype wire

// ---- dlc_limit_checker_tb_top.sv ----
// Self-checking bench for the dual limit checker
`timescale 1ns/1ps
`default_nettype none
module dlc_limit_checker_tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic bound_we_i, bound_test_i, bound_upper_i, en_we_i, en_test_i;
    logic en_val_i, cfg_we_i, master_hold_enable_i, out_enable_i;
    logic pulse_mode_i, output_polarity_select_i, reading_valid_i;
    logic [1:0] bound_ch_i, en_ch_i, reading_ch_i, rd_ch_i, clear_req_i;
    logic [1:0] auto_clear_we_i, auto_clear_val_i, test_en_o, fail_o;
    logic [1:0] auto_clear_o, high_event_o, low_event_o;
    logic [32:0] bound_val_i, reading_i, upper1_o, lower1_o;
    logic [32:0] upper2_o, lower2_o;
    logic [26:0] pulse_ms_i, pulse_ms_o;
    logic master_hold_enable_o, out_enable_o, pulse_mode_o;
    logic output_polarity_select_o, master_fail_o;
    logic [2:0] limit_line_o, limit_line_oe_o, act;
    logic [15:0] width;
    logic [32:0] ub [2][4];
    logic [32:0] lb [2][4];
    int mismatches = 0;
    int total_checks = 0;
    always #10 clk_i = ~clk_i;
    dlc_limit_checker #(.CYC_PER_MS(5)) dlc_limit_checker_inst (.*);
    dlc_line_sampler dlc_line_sampler_inst (.clk_i(clk_i),
        .rstn_i(rstn_i), .line_i(limit_line_o), .oe_i(limit_line_oe_o),
        .low_i(output_polarity_select_o), .act_o(act), .width_o(width));
    ////////////////////////////////////////////////////////////////////
    // Expected {low, high} events of one test
    function automatic logic [1:0] ev(logic [32:0] v, u, l);
        return {$signed(v) < $signed(l), $signed(v) > $signed(u)};
    endfunction
    task automatic chk(string n, logic [139:0] s, logic [139:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s exp %0h seen %0h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wb(logic t, logic u, logic [1:0] c, logic [32:0] v);
        @(negedge clk_i);
        {bound_we_i, bound_test_i, bound_upper_i} = {1'b1, t, u};
        bound_ch_i = c;
        bound_val_i = v;
        @(negedge clk_i) bound_we_i = 1'b0;
    endtask
    task automatic rd(logic [1:0] c, logic [32:0] v);
        @(negedge clk_i);
        {reading_valid_i, reading_ch_i, rd_ch_i} = {1'b1, c, c};
        reading_i = v;
        @(negedge clk_i) reading_valid_i = 1'b0;
    endtask
    // Flags are hold, out enable, pulse mode, polarity
    task automatic cfg(logic [3:0] f, logic [26:0] ms);
        @(negedge clk_i);
        {cfg_we_i, master_hold_enable_i, out_enable_i, pulse_mode_i,
            output_polarity_select_i} = {1'b1, f};
        pulse_ms_i = ms;
        @(negedge clk_i) cfg_we_i = 1'b0;
    endtask
    task automatic ac(logic [1:0] we, logic [1:0] val);
        @(negedge clk_i);
        {auto_clear_we_i, auto_clear_val_i} = {we, val};
        @(negedge clk_i) auto_clear_we_i = 2'h0;
    endtask
    // Reading with expected events and master one cycle later
    task automatic rcheck(logic [1:0] c, logic [32:0] v);
        logic [1:0] e1, e2;
        e1 = ev(v, ub[0][c], lb[0][c]);
        e2 = ev(v, ub[1][c], lb[1][c]);
        rd(c, v);
        chk("events", {high_event_o, low_event_o, fail_o}, {e2[0], e1[0],
            e2[1], e1[1], e2 != 2'h0, e1 != 2'h0});
        @(negedge clk_i);
        chk("master", master_fail_o, |{e1, e2});
    endtask
    // Hang guard
    initial begin
        #1000000;
        mismatches++;
        finish_test;
    end
    initial begin
        logic [1:0] c;
        logic [32:0] v;
        {bound_we_i, bound_test_i, bound_upper_i, en_we_i, en_test_i, en_val_i,
            cfg_we_i, master_hold_enable_i, out_enable_i, pulse_mode_i,
            output_polarity_select_i, reading_valid_i} = 12'h0;
        {bound_ch_i, en_ch_i, reading_ch_i, rd_ch_i, clear_req_i} = 10'h0;
        {auto_clear_we_i, auto_clear_val_i, pulse_ms_i} = 31'h2;
        {bound_val_i, reading_i} = 66'h0;
        void'($urandom(32'h78A9D1A4));
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd_ch_i = k[1:0];
            #1;
            chk("rst_bounds", {upper1_o, lower1_o, upper2_o, lower2_o},
                {33'h1, 33'h1FFFFFFFF, 33'h2, 33'h1FFFFFFFE});
        end
        chk("rst_cfg", {test_en_o, auto_clear_o, master_hold_enable_o,
            out_enable_o, pulse_mode_o, output_polarity_select_o, pulse_ms_o,
            fail_o, master_fail_o, limit_line_o},
            {8'h30, 27'h2, 6'h0});
        rd(2'h0, 33'h7F);
        chk("disabled", {high_event_o, low_event_o}, 4'h0);
        for (int t = 0; t < 2; t++) begin
            for (int k = 0; k < 4; k++) begin
                ub[t][k] = (k == 3) ? 33'h0FFFFFFFF : {1'b0, $urandom};
                lb[t][k] = (k == 3) ? 33'h100000001 : -{1'b0, $urandom};
                wb(t[0], 1'b1, k[1:0], ub[t][k]);
                wb(t[0], 1'b0, k[1:0], lb[t][k]);
                @(negedge clk_i);
                {en_we_i, en_test_i, en_ch_i} = {1'b1, t[0], k[1:0]};
                en_val_i = 1'b1;
                @(negedge clk_i) en_we_i = 1'b0;
            end
        end
        for (int k = 0; k < 4; k++) begin
            rd_ch_i = k[1:0];
            #1;
            chk("bounds", {upper1_o, lower1_o, upper2_o, lower2_o, test_en_o},
                {ub[0][k], lb[0][k], ub[1][k], lb[1][k], 2'h3});
        end
        for (int i = 0; i < 40; i++) begin
            c = 2'($urandom_range(3));
            case (i % 4)
                0: v = ub[i % 2][c] + 33'h1;
                1: v = ub[i % 2][c];
                2: v = lb[i % 2][c] - 33'h1;
                default: v = $urandom_range(1) ? {1'b0, $urandom}
                                               : -{1'b0, $urandom};
            endcase
            rcheck(c, v);
        end
        // Neutral reading empties test one's events first
        rd(2'h0, 33'h0);
        ac(2'h1, 2'h0);
        chk("auto_rb", auto_clear_o, 2'h2);
        rd(2'h0, ub[0][0] + 33'h1);
        rd(2'h0, 33'h0);
        chk("held", {high_event_o, low_event_o}, 4'h4);
        @(negedge clk_i) clear_req_i = 2'h1;
        @(negedge clk_i) clear_req_i = 2'h0;
        chk("cleared", {high_event_o, low_event_o}, 4'h0);
        ac(2'h1, 2'h1);
        cfg(4'h8, 27'h2);
        rd(2'h1, ub[1][1] + 33'h1);
        rd(2'h1, 33'h0);
        repeat (2) @(negedge clk_i);
        chk("hold", {fail_o, master_fail_o}, 3'h1);
        cfg(4'h0, 27'h2);
        repeat (2) @(negedge clk_i);
        chk("release", master_fail_o, 1'b0);
        for (int p = 0; p < 2; p++) begin
            cfg({3'b010, p[0]}, 27'h2);
            rd(2'h2, lb[0][2] - 33'h1);
            repeat (4) @(negedge clk_i);
            chk("line", {act[0], act[2], limit_line_o[0], limit_line_o[2],
                limit_line_oe_o}, {2'b11, ~p[0], ~p[0], 3'h7});
            rd(2'h2, 33'h0);
            repeat (6) @(negedge clk_i);
        end
        for (int k = 0; k < 2; k++) begin
            cfg(4'h6, k ? 27'h0 : 27'h2);
            chk("ms_rb", {pulse_mode_o, pulse_ms_o},
                {1'b1, k ? 27'h1 : 27'h2});
            rd(2'h3, lb[0][3] - 33'h1);
            repeat (30) @(negedge clk_i);
            rd(2'h3, 33'h0);
            repeat (8) @(negedge clk_i);
            chk("pulse_w", width, k ? 16'h5 : 16'hA);
        end
        cfg(4'h0, 27'h7FFFFFF);
        repeat (3) @(negedge clk_i);
        chk("off", {pulse_ms_o, limit_line_o, limit_line_oe_o},
            {27'h5F5E0FF, 6'h0});
        finish_test;
    end
endmodule // dlc_limit_checker_tb_top
`default_nettype wire
